// ---- design/fwc_consts.svh ----
// Offsets, field positions, reset values and timing counts of the flash write control block.
`ifndef FWC_CONSTS_SVH
`define FWC_CONSTS_SVH
`define FWC_ADDR_CONTROL 8'h00
`define FWC_ADDR_STATUS 8'h01
`define FWC_ADDR_WTIME 8'h02
`define FWC_ADDR_IRQ_STATUS 8'h03
`define FWC_ADDR_IRQ_MASK 8'h04
`define FWC_CTRL_POWER_BIT 0
`define FWC_CTRL_STOP_BIT 1
`define FWC_CTRL_PROTECT_LSB 4
`define FWC_STAT_BUSY_BIT 0
`define FWC_STAT_READY_BIT 1
`define FWC_STAT_INTW_BIT 2
`define FWC_PROTECT_ENABLE 4'h3
`define FWC_PROTECT_DISABLE 4'hC
`define FWC_WTIME_RESET 3'h0
`define FWC_WTIME_MAX_CODE 3'h4
`define FWC_FLASH_LOW 16'h4000
`define FWC_PAGE_BYTES 8'h80
`define FWC_WARM_HF_CYCLES 17'h00400
`define FWC_WARM_LF_CYCLES 17'h00008
`define FWC_PROG_HF_BASE 17'h10000
`define FWC_PROG_LF_BASE 17'h00080
`define FWC_PROG_TIME_MS 4
`define FWC_ERASED_BYTE 8'hFF
`endif

// ---- design/fwc_pkg.sv ----
// Types shared by the flash write control block.
package fwc_pkg;
    typedef enum logic [1:0] {
        FWC_IDLE,
        FWC_FILL,
        FWC_PROG,
        FWC_WARM
    } fwc_state_type;
endpackage

// ---- design/fwc_flash_write_control.sv ----
// Flash page write control: protect code, power monitor, busy and interrupted-write flags.
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "fwc_consts.svh"

// Overview of operation
// [R1] Non-maskable interrupt during write sets flag, aborts, clears counter, warms up with CPU stalled.
// [R2] Reading the status register clears the interrupted-write flag.
// [R3] Non-maskable interrupt during warm-up keeps CPU halted until warm-up ends.
// [R4] Power bit rising raises ready after 2^10 fast or 2^3 slow clocks.
// [R5] Ready monitor is read-only, low while off or warming up.
// [R6] While busy, flash reads and fetches return FFH; a fetched FFH raises software interrupt.
// [R7] Write-time code 000..100 selects 2^16..2^12 fast or 2^7..2^3 slow periods.
// [R8] On the real part the selector is storage only; program time is fixed.
// [R9] Upper bits 7..3 of the write-time register read undefined.
// [R10] Protect code 0011 enables writes, 1100 disables them.
// [R11] Reset loads protect code 1100.
// [R12] Protect and power writes take effect only when fetched from RAM.
// [R13] Flash range 4000H..FFFFH accepts writes only in serial PROM mode.
// [R14] Software keeps protect code at 1100 except when writing.
// [R15] Software checks ready before touching flash.
// [R16] Software repeats a page write that the interrupt flagged.
// [R17] Writes stage in a 128-byte page buffer, programmed once full.
// [R18] Clearing the power bit turns the control circuit off at once.
// [R19] Busy rises with the first buffered byte, falls on program end; after an abort it stays high until the warm-up ends.
module fwc_flash_write_control #(
    parameter bit EMULATION = 1'b0
) (
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic FETCH_FROM_RAM,
    input wire logic NMI_REQ,
    input wire logic SERIAL_PROM_MODE,
    input wire logic SYSTEM_CLOCK_SELECT,
    input wire logic LOW_FREQ_CLOCK,
    input wire logic FLASH_OSC_TICK,
    input wire logic [15:0] FLASH_ADDR,
    input wire logic [7:0] FLASH_WDATA,
    input wire logic FLASH_WR,
    input wire logic FLASH_RD,
    input wire logic FLASH_FETCH,
    input wire logic [7:0] FLASH_ARRAY_DATA,
    output logic [7:0] FLASH_RDATA,
    output logic [7:0] PAGE_WR_DATA,
    output logic [6:0] PAGE_WR_INDEX,
    output logic PAGE_WR_STROBE,
    output logic PAGE_PROGRAM,
    output logic [15:0] PAGE_BASE,
    output logic CPU_STALL,
    output logic SOFTWARE_INT,
    output logic FLASH_POWER_ON,
    output logic IRQ
);
    logic [1:0] lf_sync;
    logic [1:0] tick_sync;
    logic lf_last;
    logic tick_last;
    logic lf_edge;
    logic tick_edge;
    logic manual_power;
    logic [3:0] protect_code;
    logic [2:0] write_time_select;
    logic power_ready;
    logic interrupted_write_flag;
    logic write_busy;
    logic warm_active;
    logic warm_stall;
    logic [16:0] warm_count;
    logic [16:0] prog_count;
    logic [16:0] prog_target;
    logic [7:0] fill_count;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [7:0] undefined_bits;
    logic [1:0] osc_tick_count;
    fwc_pkg::fwc_state_type state;
    fwc_pkg::fwc_state_type next_state;
    logic wr_ctrl;
    logic rd_stat;
    logic write_allowed;
    logic buffer_write;
    logic abort_req;
    logic page_done;
    logic prog_done;
    logic warm_done;
    logic power_rise;
    logic slow_tick;
    logic warm_tick;

    assign wr_ctrl = REG_WR && (REG_ADDR == `FWC_ADDR_CONTROL) && FETCH_FROM_RAM; // [R12]
    assign rd_stat = REG_RD && (REG_ADDR == `FWC_ADDR_STATUS);
    assign write_allowed = (protect_code == `FWC_PROTECT_ENABLE) && SERIAL_PROM_MODE && power_ready; // [R10] [R13]
    assign buffer_write = FLASH_WR && (FLASH_ADDR >= `FWC_FLASH_LOW) && write_allowed
        && (state == fwc_pkg::FWC_IDLE || state == fwc_pkg::FWC_FILL); // [R13] [R17]
    // Only a fill or a program can be aborted, so an interrupt during recovery never restarts the warm-up.
    assign abort_req = (state == fwc_pkg::FWC_FILL || state == fwc_pkg::FWC_PROG)
        && (NMI_REQ || (wr_ctrl && REG_WDATA[`FWC_CTRL_STOP_BIT])); // [R1] [R3]
    assign page_done = buffer_write && (fill_count == `FWC_PAGE_BYTES - 8'h01); // [R17]
    assign slow_tick = SYSTEM_CLOCK_SELECT ? lf_edge : 1'b1;
    assign warm_tick = slow_tick;
    assign warm_done = warm_active && warm_tick && (warm_count == 17'h00001);
    assign power_rise = wr_ctrl && REG_WDATA[`FWC_CTRL_POWER_BIT] && !manual_power;

    // The slow clock and the flash oscillator come from outside this domain.
    always_ff @(posedge REF_CLK) begin
        lf_sync <= {lf_sync[0], LOW_FREQ_CLOCK};
        tick_sync <= {tick_sync[0], FLASH_OSC_TICK};
        lf_last <= lf_sync[1];
        tick_last <= tick_sync[1];
    end
    assign lf_edge = lf_sync[1] && !lf_last;
    assign tick_edge = tick_sync[1] && !tick_last;

    // Write-time periods halve per code step; reserved codes fall back to the shortest time.
    always_comb begin
        logic [2:0] code;
        code = (write_time_select > `FWC_WTIME_MAX_CODE) ? `FWC_WTIME_MAX_CODE : write_time_select;
        if (SYSTEM_CLOCK_SELECT) begin
            prog_target = `FWC_PROG_LF_BASE >> code; // [R7]
        end else begin
            prog_target = `FWC_PROG_HF_BASE >> code; // [R7]
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            fwc_pkg::FWC_IDLE: begin
                if (buffer_write) begin
                    next_state = fwc_pkg::FWC_FILL; // [R19]
                end
            end
            fwc_pkg::FWC_FILL: begin
                if (abort_req) begin
                    next_state = fwc_pkg::FWC_WARM; // [R1]
                end else if (page_done) begin
                    next_state = fwc_pkg::FWC_PROG;
                end
            end
            fwc_pkg::FWC_PROG: begin
                if (abort_req) begin
                    next_state = fwc_pkg::FWC_WARM; // [R1]
                end else if (prog_done) begin
                    next_state = fwc_pkg::FWC_IDLE; // [R19]
                end
            end
            fwc_pkg::FWC_WARM: begin
                if (warm_done) begin
                    next_state = fwc_pkg::FWC_IDLE; // [R19]
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            state <= fwc_pkg::FWC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Page fill counter and staged write strobe toward the page buffer.
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            fill_count <= 8'h00;
            PAGE_WR_STROBE <= 1'b0;
            PAGE_WR_DATA <= 8'h00;
            PAGE_WR_INDEX <= 7'h00;
            PAGE_BASE <= 16'h0000;
            PAGE_PROGRAM <= 1'b0;
        end else begin
            PAGE_WR_STROBE <= buffer_write && !abort_req;
            PAGE_PROGRAM <= page_done && !abort_req;
            if (buffer_write) begin
                PAGE_WR_DATA <= FLASH_WDATA;
                PAGE_WR_INDEX <= fill_count[6:0];
            end
            if (buffer_write && state == fwc_pkg::FWC_IDLE) begin
                PAGE_BASE <= {FLASH_ADDR[15:7], 7'h00};
            end
            if (abort_req || page_done) begin
                fill_count <= 8'h00; // [R1]
            end else if (buffer_write) begin
                fill_count <= fill_count + 8'h01; // [R17]
            end
        end
    end

    // Program timer: emulation counts the selected period, the real part counts its own oscillator.
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            prog_count <= 17'h00000;
            osc_tick_count <= 2'h0;
            prog_done <= 1'b0;
        end else begin
            prog_done <= 1'b0;
            if (state != fwc_pkg::FWC_PROG) begin
                prog_count <= 17'h00000;
                osc_tick_count <= 2'h0;
            end else if (EMULATION) begin
                if (slow_tick) begin
                    prog_count <= prog_count + 17'h00001;
                    prog_done <= (prog_count + 17'h00001 >= prog_target); // [R7]
                end
            end else if (tick_edge) begin
                osc_tick_count <= osc_tick_count + 2'h1;
                prog_done <= (osc_tick_count == 2'(`FWC_PROG_TIME_MS - 1)); // [R8]
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            write_busy <= 1'b0;
        end else if (next_state == fwc_pkg::FWC_IDLE) begin
            write_busy <= 1'b0; // [R19]
        end else begin
            write_busy <= 1'b1; // [R19]
        end
    end

    // One warm-up counter serves power-up and abort recovery.
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            manual_power <= 1'b1;
            warm_active <= 1'b1;
            warm_stall <= 1'b1;
            warm_count <= `FWC_WARM_HF_CYCLES;
            power_ready <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                manual_power <= REG_WDATA[`FWC_CTRL_POWER_BIT]; // [R12]
            end else if (NMI_REQ && !manual_power) begin
                manual_power <= 1'b1;
            end
            if (wr_ctrl && !REG_WDATA[`FWC_CTRL_POWER_BIT]) begin
                warm_active <= 1'b0; // [R18]
                warm_stall <= 1'b0;
                power_ready <= 1'b0; // [R18]
            end else if (power_rise || abort_req || (NMI_REQ && !manual_power)) begin
                warm_active <= 1'b1; // [R4]
                warm_stall <= abort_req || NMI_REQ || warm_stall; // [R1] [R3]
                power_ready <= 1'b0; // [R5]
                warm_count <= SYSTEM_CLOCK_SELECT ? `FWC_WARM_LF_CYCLES : `FWC_WARM_HF_CYCLES; // [R4]
            end else if (warm_active) begin
                if (NMI_REQ) begin
                    warm_stall <= 1'b1; // [R3]
                end
                if (warm_done) begin
                    warm_active <= 1'b0;
                    warm_stall <= 1'b0; // [R3]
                    power_ready <= 1'b1; // [R4]
                end else if (warm_tick) begin
                    warm_count <= warm_count - 17'h00001;
                end
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            interrupted_write_flag <= 1'b0;
        end else if (abort_req && NMI_REQ) begin
            interrupted_write_flag <= 1'b1; // [R1]
        end else if (rd_stat) begin
            interrupted_write_flag <= 1'b0; // [R2]
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            protect_code <= `FWC_PROTECT_DISABLE; // [R11]
            write_time_select <= `FWC_WTIME_RESET;
            irq_mask <= 3'h0;
        end else if (REG_WR) begin
            if (wr_ctrl) begin
                protect_code <= REG_WDATA[`FWC_CTRL_PROTECT_LSB +: 4]; // [R12]
            end
            if (REG_ADDR == `FWC_ADDR_WTIME) begin
                write_time_select <= REG_WDATA[2:0]; // [R8]
            end
            if (REG_ADDR == `FWC_ADDR_IRQ_MASK) begin
                irq_mask <= REG_WDATA[2:0];
            end
        end
    end

    // Events: interrupted write, power ready, page program finished. Set wins over clear.
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            irq_status <= 3'h0;
        end else begin
            irq_status <= (irq_status & ~((REG_WR && REG_ADDR == `FWC_ADDR_IRQ_STATUS) ? REG_WDATA[2:0] : 3'h0))
                | {prog_done, warm_done && !write_busy, abort_req && NMI_REQ};
        end
    end
    assign IRQ = |(irq_status & irq_mask);

    // Upper write-time bits float; a free-running pattern models that they carry no meaning.
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            undefined_bits <= 8'h00;
        end else begin
            undefined_bits <= undefined_bits + 8'h28;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                `FWC_ADDR_CONTROL: REG_RDATA <= {protect_code, 3'h0, manual_power};
                `FWC_ADDR_STATUS: REG_RDATA <= {5'h00, interrupted_write_flag, power_ready, write_busy}; // [R5]
                `FWC_ADDR_WTIME: REG_RDATA <= {undefined_bits[7:3], write_time_select}; // [R9]
                `FWC_ADDR_IRQ_STATUS: REG_RDATA <= {5'h00, irq_status};
                `FWC_ADDR_IRQ_MASK: REG_RDATA <= {5'h00, irq_mask};
                default: REG_RDATA <= 8'h00;
            endcase
        end else begin
            REG_RDATA <= 8'h00;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            FLASH_RDATA <= 8'h00;
            SOFTWARE_INT <= 1'b0;
        end else begin
            SOFTWARE_INT <= 1'b0;
            if (FLASH_RD || FLASH_FETCH) begin
                if (write_busy || !power_ready) begin
                    FLASH_RDATA <= `FWC_ERASED_BYTE; // [R6]
                    SOFTWARE_INT <= FLASH_FETCH; // [R6]
                end else begin
                    FLASH_RDATA <= FLASH_ARRAY_DATA;
                    SOFTWARE_INT <= FLASH_FETCH && (FLASH_ARRAY_DATA == `FWC_ERASED_BYTE);
                end
            end
        end
    end

    assign CPU_STALL = warm_stall; // [R1] [R3]
    assign FLASH_POWER_ON = manual_power; // [R18]
endmodule

// ---- bench/fwc_flash_write_control_properties.sv ----
// Concurrent checks on the ports of the flash write control block.
`timescale 1ns/1ps
`include "fwc_consts.svh"
module fwc_write_control_checker (
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic FETCH_FROM_RAM,
    input wire logic NMI_REQ,
    input wire logic SERIAL_PROM_MODE,
    input wire logic SYSTEM_CLOCK_SELECT,
    input wire logic [15:0] FLASH_ADDR,
    input wire logic [7:0] FLASH_WDATA,
    input wire logic FLASH_WR,
    input wire logic FLASH_FETCH,
    input wire logic [7:0] FLASH_RDATA,
    input wire logic [7:0] PAGE_WR_DATA,
    input wire logic [6:0] PAGE_WR_INDEX,
    input wire logic PAGE_WR_STROBE,
    input wire logic PAGE_PROGRAM,
    input wire logic CPU_STALL,
    input wire logic SOFTWARE_INT,
    input wire logic FLASH_POWER_ON
);
    logic [10:0] stall_cnt;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);
    // Saturates so that a stuck stall cannot wrap round into a short count.
    always_ff @(posedge REF_CLK) begin
        if (!NRST || !CPU_STALL) stall_cnt <= 11'h000;
        else if (stall_cnt != 11'h7FF) stall_cnt <= stall_cnt + 11'h001;
    end
    AST_POWER_OFF: assert property (REG_WR && REG_ADDR == `FWC_ADDR_CONTROL && FETCH_FROM_RAM
        && !REG_WDATA[0] && !NMI_REQ |=> !FLASH_POWER_ON) else $error("power stayed on after clear");
    AST_PROTECT_ROM: assert property (REG_WR && REG_ADDR == `FWC_ADDR_CONTROL && !FETCH_FROM_RAM
        && !NMI_REQ |=> FLASH_POWER_ON == $past(FLASH_POWER_ON)) else $error("control write from flash took effect");
    AST_LOW_AREA: assert property (FLASH_WR && FLASH_ADDR < `FWC_FLASH_LOW |=> !PAGE_WR_STROBE)
        else $error("write below flash area was buffered");
    AST_SERIAL_ONLY: assert property (FLASH_WR && !SERIAL_PROM_MODE |=> !PAGE_WR_STROBE)
        else $error("write outside serial mode was buffered");
    AST_POWERED_ONLY: assert property (FLASH_WR && !FLASH_POWER_ON |=> !PAGE_WR_STROBE)
        else $error("write while powered off was buffered");
    AST_FETCH_SWI: assert property (SOFTWARE_INT |-> $past(FLASH_FETCH) && FLASH_RDATA == `FWC_ERASED_BYTE)
        else $error("software interrupt without erased fetch");
    AST_STAGED_DATA: assert property (PAGE_WR_STROBE |-> $past(FLASH_WR) && PAGE_WR_DATA == $past(FLASH_WDATA))
        else $error("buffered byte differs from written byte");
    AST_LAST_BYTE: assert property (PAGE_WR_STROBE && PAGE_WR_INDEX != 7'h7F |-> !PAGE_PROGRAM)
        else $error("page programmed before last byte");
    AST_NMI_HOLD: assert property (NMI_REQ && CPU_STALL |=> CPU_STALL)
        else $error("stall dropped on interrupt during warm-up");
    AST_WARM_LENGTH: assert property ($fell(CPU_STALL) && !SYSTEM_CLOCK_SELECT |-> stall_cnt >= 11'h3E8)
        else $error("warm-up stall too short");
endmodule
bind fwc_flash_write_control fwc_write_control_checker i_chk (.REF_CLK(REF_CLK), .NRST(NRST),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .FETCH_FROM_RAM(FETCH_FROM_RAM),
    .NMI_REQ(NMI_REQ), .SERIAL_PROM_MODE(SERIAL_PROM_MODE), .SYSTEM_CLOCK_SELECT(SYSTEM_CLOCK_SELECT),
    .FLASH_ADDR(FLASH_ADDR), .FLASH_WDATA(FLASH_WDATA), .FLASH_WR(FLASH_WR), .FLASH_FETCH(FLASH_FETCH),
    .FLASH_RDATA(FLASH_RDATA), .PAGE_WR_DATA(PAGE_WR_DATA), .PAGE_WR_INDEX(PAGE_WR_INDEX),
    .PAGE_WR_STROBE(PAGE_WR_STROBE), .PAGE_PROGRAM(PAGE_PROGRAM), .CPU_STALL(CPU_STALL),
    .SOFTWARE_INT(SOFTWARE_INT), .FLASH_POWER_ON(FLASH_POWER_ON));

// ---- bench/fwc_cpu_model.sv ----
// Model of the CPU core issuing register and flash accesses to the block.
`timescale 1ns/1ps
module fwc_cpu_model (
    input wire logic clk,
    input wire logic stall,
    input wire logic [7:0] rdata,
    input wire logic [7:0] frdata,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic from_ram,
    output logic [15:0] flash_addr,
    output logic [7:0] flash_wdata,
    output logic flash_wr,
    output logic flash_rd,
    output logic flash_fetch,
    output logic [7:0] array_data
);
    // The array holds the erased value only at addresses ending in A5H, which the bench never reads, so an FFH answer comes from the block.
    assign array_data = flash_addr[7:0] ^ 8'h5A;
    initial begin
        {reg_addr, reg_wdata, reg_wr, reg_rd, from_ram} = 19'h00001;
        {flash_addr, flash_wdata, flash_wr, flash_rd, flash_fetch} = 27'h0000000;
    end
    // A halted core issues nothing; a stall that never ends is left to the bench's watchdog.
    task automatic hold();
        while (stall !== 1'b0) begin
            @(posedge clk);
        end
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] w, input logic ram);
        hold();
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr, from_ram} <= {a, w, 1'b1, ram};
        @(posedge clk);
        {reg_addr, reg_wdata, reg_wr} <= {~a, ~w, 1'b0};
        #1;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        hold();
        @(posedge clk);
        {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge clk);
        {reg_addr, reg_rd} <= {~a, 1'b0};
        #1 d = rdata;
    endtask
    // Kind 0 writes, 1 reads, 2 fetches an instruction byte.
    task automatic flash_op(input logic [1:0] kind, input logic [15:0] a, input logic [7:0] w, output logic [7:0] d);
        hold();
        @(posedge clk);
        {flash_addr, flash_wdata} <= {a, w};
        {flash_wr, flash_rd, flash_fetch} <= {kind == 2'h0, kind == 2'h1, kind == 2'h2};
        @(posedge clk);
        {flash_addr, flash_wdata, flash_wr, flash_rd, flash_fetch} <= {~a, ~w, 3'h0};
        #1 d = frdata;
    endtask
endmodule

// ---- bench/test_flash_write_control.sv ----
// Self-checking testbench of the flash write control block.
`timescale 1ns/1ps
module test_flash_write_control;
    logic ref_clk, nrst, nmi, serial, system_clock_select, lfc, osc, page_wr_strobe, page_program, cpu_stall;
    logic software_int, flash_power_on, irq, reg_wr, reg_rd, from_ram, flash_wr, flash_rd, flash_fetch;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, flash_wdata, array_data, flash_rdata, page_wr_data, d;
    logic [15:0] flash_addr, page_base;
    logic [6:0] page_wr_index, last_index;
    int err_count = 0, comparisons = 0, n_strobe = 0, n_prog = 0, n_swi = 0;
    fwc_flash_write_control i_dut (.REF_CLK(ref_clk), .NRST(nrst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .FETCH_FROM_RAM(from_ram), .NMI_REQ(nmi),
        .SERIAL_PROM_MODE(serial), .SYSTEM_CLOCK_SELECT(system_clock_select), .LOW_FREQ_CLOCK(lfc), .FLASH_OSC_TICK(osc),
        .FLASH_ADDR(flash_addr), .FLASH_WDATA(flash_wdata), .FLASH_WR(flash_wr), .FLASH_RD(flash_rd),
        .FLASH_FETCH(flash_fetch), .FLASH_ARRAY_DATA(array_data), .FLASH_RDATA(flash_rdata),
        .PAGE_WR_DATA(page_wr_data), .PAGE_WR_INDEX(page_wr_index), .PAGE_WR_STROBE(page_wr_strobe),
        .PAGE_PROGRAM(page_program), .PAGE_BASE(page_base), .CPU_STALL(cpu_stall), .SOFTWARE_INT(software_int),
        .FLASH_POWER_ON(flash_power_on), .IRQ(irq));
    fwc_cpu_model i_cpu (.clk(ref_clk), .stall(cpu_stall), .rdata(reg_rdata), .frdata(flash_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .from_ram(from_ram),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_wr(flash_wr), .flash_rd(flash_rd),
        .flash_fetch(flash_fetch), .array_data(array_data));
    initial begin
        {ref_clk, lfc, osc} = 3'h0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Slow clock of 40 cycles and a program oscillator tick every 100 cycles, far faster than 1 ms.
    always #80 lfc = ~lfc;
    always #200 osc = ~osc;
    always @(posedge ref_clk) begin
        if (page_wr_strobe === 1'b1) begin
            n_strobe++;
            last_index = page_wr_index;
        end
        if (page_program === 1'b1) n_prog++;
        if (software_int === 1'b1) n_swi++;
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic t_reset();
        i_cpu.read_reg(8'h01, d);
        chk8(d, 8'h02);
        i_cpu.read_reg(8'h00, d);
        chk8(d & 8'hF1, 8'hC1);
    endtask
    task automatic t_protect();
        i_cpu.write_reg(8'h00, 8'h31, 1'b0);
        i_cpu.read_reg(8'h00, d);
        chk8(d & 8'hF1, 8'hC1);
        i_cpu.flash_op(2'h0, 16'h4000, 8'h11, d);
        settle(2);
        chk8(8'(n_strobe), 8'h00);
        i_cpu.write_reg(8'h00, 8'h31, 1'b1);
        i_cpu.flash_op(2'h0, 16'h3FFF, 8'h22, d);
        settle(2);
        chk8(8'(n_strobe), 8'h00);
        @(posedge ref_clk) serial <= 1'b0;
        i_cpu.flash_op(2'h0, 16'h4000, 8'h33, d);
        settle(2);
        chk8(8'(n_strobe), 8'h00);
        @(posedge ref_clk) serial <= 1'b1;
        i_cpu.flash_op(2'h0, 16'h4000, 8'hA5, d);
        settle(2);
        chk8(8'(n_strobe), 8'h01);
        i_cpu.read_reg(8'h01, d);
        chk8(d, 8'h03);
        i_cpu.flash_op(2'h1, 16'h4001, 8'h00, d);
        chk8(d, 8'hFF);
        i_cpu.flash_op(2'h2, 16'h4002, 8'h00, d);
        settle(1);
        chk8(d, 8'hFF);
        chk8(8'(n_swi), 8'h01);
    endtask
    task automatic t_nmi();
        @(posedge ref_clk) nmi <= 1'b1;
        @(posedge ref_clk) nmi <= 1'b0;
        settle(1);
        chk1(cpu_stall, 1'b1);
        repeat (500) @(posedge ref_clk);
        nmi <= 1'b1;
        @(posedge ref_clk) nmi <= 1'b0;
        settle(2);
        chk1(cpu_stall, 1'b1);
        i_cpu.read_reg(8'h01, d);
        chk8(d, 8'h06);
        i_cpu.read_reg(8'h01, d);
        chk8(d, 8'h02);
        i_cpu.flash_op(2'h0, 16'h4000, 8'h00, d);
        settle(2);
        chk8({1'b0, last_index}, 8'h00);
    endtask
    task automatic t_page();
        for (int i = 1; i < 128; i++) i_cpu.flash_op(2'h0, 16'h4000 + 16'(i), 8'(i), d);
        settle(2);
        chk8(8'(n_prog), 8'h01);
        chk8({1'b0, last_index}, 8'h7F);
        chk8(page_base[15:8], 8'h40);
        chk8(page_base[7:0], 8'h00);
        i_cpu.read_reg(8'h01, d);
        chk8(d, 8'h03);
        settle(250);
        i_cpu.read_reg(8'h01, d);
        chk8(d, 8'h03);
        settle(300);
        i_cpu.read_reg(8'h01, d);
        chk8(d, 8'h02);
        i_cpu.write_reg(8'h00, 8'hC1, 1'b1);
        i_cpu.flash_op(2'h0, 16'h4000, 8'h44, d);
        settle(2);
        chk8(8'(n_strobe), 8'h81);
    endtask
    task automatic t_irq();
        i_cpu.read_reg(8'h03, d);
        chk8(d, 8'h07);
        i_cpu.write_reg(8'h04, 8'h00, 1'b1);
        chk1(irq, 1'b0);
        i_cpu.write_reg(8'h04, 8'h07, 1'b1);
        chk1(irq, 1'b1);
        i_cpu.write_reg(8'h03, 8'h07, 1'b1);
        chk1(irq, 1'b0);
        i_cpu.read_reg(8'h03, d);
        chk8(d & 8'h07, 8'h00);
    endtask
    task automatic t_power();
        int early[2] = '{1000, 250};
        int late[2] = '{40, 200};
        for (int s = 0; s < 2; s++) begin
            @(posedge ref_clk) system_clock_select <= s[0];
            i_cpu.write_reg(8'h00, 8'hC0, 1'b1);
            chk1(flash_power_on, 1'b0);
            i_cpu.read_reg(8'h01, d);
            chk8(d, 8'h00);
            i_cpu.flash_op(2'h1, 16'h8000, 8'h00, d);
            chk8(d, 8'hFF);
            i_cpu.write_reg(8'h00, 8'hC1, 1'b1);
            settle(early[s]);
            i_cpu.read_reg(8'h01, d);
            chk8(d, 8'h00);
            settle(late[s]);
            i_cpu.read_reg(8'h01, d);
            chk8(d, 8'h02);
        end
        @(posedge ref_clk) system_clock_select <= 1'b0;
    endtask
    task automatic t_wtime();
        for (int c = 0; c < 8; c++) begin
            i_cpu.write_reg(8'h02, 8'(c), 1'b1);
            i_cpu.read_reg(8'h02, d);
            chk8({5'h00, d[2:0]}, 8'(c));
        end
        i_cpu.read_reg(8'h10, d);
        chk8(d, 8'h00);
    endtask
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // The whole sequence needs about 4500 cycles; the limit leaves ample margin.
    initial begin
        #200000;
        err_count++;
        end_of_test();
    end
    initial begin
        {nrst, nmi, serial, system_clock_select} = 4'h2;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset();
        t_protect();
        t_nmi();
        t_page();
        t_irq();
        t_power();
        t_wtime();
        end_of_test();
    end
endmodule
